// >>> pkg/rcf_pkg.sv
// Constants for the reader command, host-access and byte-queue registers
// What this block does
// R1: Command bit 7 set enters standby
// R2: Command bit 6 powers down receiver, transmitter
// R3: Command bits 4..0 hold command; bit 5 reserved
// R4: Unlock bit allows next write, then clears
// R5: Host ownership set only after unlock
// R6: Secure-module ownership needs unlock, never with host
// R7: Bits 3..2 select secure-module link type
// R8: Queue control bit 7: 1=255, 0=512 bytes
// R9: Host changes depth only after clearing queue; the block stores bit 7 on any queue control write
// R10: Near-full when capacity minus fill <= threshold
// R11: Near-empty when fill <= threshold
// R12: Clear bit empties queue, reads zero
// R13: Threshold msb used only in 512 mode
// R14: Read-only bits 1..0 show fill bits 9..8
// R15: Threshold register: full eight-bit read-write
// R16: Data port write pushes, read pops
// R17: Fill register shows low eight bits, resets zero
// R18: Full write dropped; empty read returns zero
// R19: Setting both ownership bits keeps previous values
package rcf_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W = 10;
  localparam int THR_W = 9;

  localparam logic [ADDR_W-1:0] ADR_COMMAND = 7'h00;
  localparam logic [ADDR_W-1:0] ADR_HOST_CTRL = 7'h01;
  localparam logic [ADDR_W-1:0] ADR_QUEUE_CTRL = 7'h02;
  localparam logic [ADDR_W-1:0] ADR_THRESHOLD = 7'h03;
  localparam logic [ADDR_W-1:0] ADR_FILL_COUNT = 7'h04;
  localparam logic [ADDR_W-1:0] ADR_QUEUE_PORT = 7'h05;

  localparam int CMD_STANDBY_BIT = 7;
  localparam int CMD_RF_OFF_BIT = 6;
  localparam int CMD_CODE_MSB = 4;
  localparam int CMD_CODE_W = 5;

  localparam int HC_UNLOCK_BIT = 7;
  localparam int HC_OWN_HOST_BIT = 6;
  localparam int HC_OWN_SAM_BIT = 5;
  localparam int HC_LINK_MSB = 3;
  localparam int HC_LINK_LSB = 2;

  localparam int QC_DEPTH_BIT = 7;
  localparam int QC_NFULL_BIT = 6;
  localparam int QC_NEMPTY_BIT = 5;
  localparam int QC_CLEAR_BIT = 4;
  localparam int QC_THR_MSB_BIT = 2;

  localparam logic [CNT_W-1:0] DEPTH_SMALL = 10'h0FF;
  localparam logic [CNT_W-1:0] DEPTH_LARGE = 10'h200;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT = 10'h000;
  localparam logic [CMD_CODE_W-1:0] RST_CMD = 5'h00;
  localparam logic [1:0] RST_LINK = 2'h0;
  localparam logic [1:0] LINK_OFF = 2'h0;
  localparam logic [1:0] LINK_SPI = 2'h1;
  localparam logic [1:0] LINK_ALT_TWO_WIRE = 2'h2;
  localparam logic [1:0] LINK_I2C = 2'h3;
endpackage

// >>> hdl/rcf_top.sv
// Command, host-access control and byte queue register block
module rcf_top #(
  parameter int PTR_W = 9
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [rcf_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [rcf_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [rcf_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic standby_out,
  output logic rf_frontend_powerdown_out,
  output logic [rcf_pkg::CMD_CODE_W-1:0] command_code_out,
  output logic bus_owner_host_out,
  output logic bus_owner_secure_module_out,
  output logic [1:0] secure_module_link_select_out,
  output logic near_full_flag_out,
  output logic near_empty_flag_out
);

  localparam int MEM_DEPTH = 2 ** PTR_W;

  if (MEM_DEPTH < int'(rcf_pkg::DEPTH_LARGE)) begin : g_bad_depth
    $error("PTR_W too small for the 512-byte queue");
  end

  if (rcf_pkg::THR_W + 1 != rcf_pkg::CNT_W) begin : g_bad_thr
    $error("threshold width must be one below the fill count width");
  end

  // Storage
  logic [rcf_pkg::DATA_W-1:0] mem [MEM_DEPTH];

  // Registers
  logic standby_ff;
  logic rf_off_ff;
  logic [rcf_pkg::CMD_CODE_W-1:0] cmd_ff;
  logic unlock_ff;
  logic own_host_ff;
  logic own_sam_ff;
  logic [1:0] link_ff;
  logic depth_sel_ff;
  logic thr_msb_ff;
  logic [rcf_pkg::DATA_W-1:0] thr_lo_ff;
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [rcf_pkg::CNT_W-1:0] count_ff;
  logic [rcf_pkg::DATA_W-1:0] rdata_ff;
  logic rvalid_ff;
  logic near_full_ff;
  logic near_empty_ff;

  // Address decode
  wire sel_cmd = (reg_addr_in == rcf_pkg::ADR_COMMAND);
  wire sel_hc = (reg_addr_in == rcf_pkg::ADR_HOST_CTRL);
  wire sel_qc = (reg_addr_in == rcf_pkg::ADR_QUEUE_CTRL);
  wire sel_thr = (reg_addr_in == rcf_pkg::ADR_THRESHOLD);
  wire sel_cnt = (reg_addr_in == rcf_pkg::ADR_FILL_COUNT);
  wire sel_port = (reg_addr_in == rcf_pkg::ADR_QUEUE_PORT);

  wire wr_cmd = reg_wr_in && sel_cmd;
  wire wr_hc = reg_wr_in && sel_hc;
  wire wr_qc = reg_wr_in && sel_qc;
  wire wr_thr = reg_wr_in && sel_thr;
  wire wr_port = reg_wr_in && sel_port;
  wire rd_port = reg_rd_in && sel_port && !reg_wr_in;

  // Queue capacity and threshold
  wire [rcf_pkg::CNT_W-1:0] capacity =
    depth_sel_ff ? rcf_pkg::DEPTH_SMALL : rcf_pkg::DEPTH_LARGE; // R8
  wire [rcf_pkg::THR_W-1:0] threshold =
    depth_sel_ff ? {1'b0, thr_lo_ff} : {thr_msb_ff, thr_lo_ff}; // R13 R15
  wire q_full = (count_ff >= capacity);
  wire q_empty = (count_ff == rcf_pkg::RST_COUNT);
  wire [rcf_pkg::CNT_W-1:0] room = q_full ? rcf_pkg::RST_COUNT : capacity - count_ff;
  wire near_full = (room <= {1'b0, threshold}); // R10
  wire near_empty = (count_ff <= {1'b0, threshold}); // R11

  // Queue operations
  wire q_clear = wr_qc && reg_wdata_in[rcf_pkg::QC_CLEAR_BIT]; // R12
  wire push = wr_port && !q_full; // R16 R18
  wire pop = rd_port && !q_empty; // R16 R18

  wire [rcf_pkg::CNT_W-1:0] nxt_count =
    q_clear ? rcf_pkg::RST_COUNT :
    push ? count_ff + 10'h001 :
    pop ? count_ff - 10'h001 : count_ff;
  wire [PTR_W-1:0] nxt_wr_ptr =
    q_clear ? '0 : (push ? wr_ptr_ff + 1'b1 : wr_ptr_ff);
  wire [PTR_W-1:0] nxt_rd_ptr =
    q_clear ? '0 : (pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff);

  // Host-access control update
  wire req_host = reg_wdata_in[rcf_pkg::HC_OWN_HOST_BIT];
  wire req_sam = reg_wdata_in[rcf_pkg::HC_OWN_SAM_BIT];
  wire both_req = req_host && req_sam; // R19
  wire own_write = wr_hc && unlock_ff && !both_req; // R5 R6
  wire nxt_own_host =
    own_write ? req_host :
    (wr_hc && !req_host) ? 1'b0 : own_host_ff; // R5
  wire nxt_own_sam =
    own_write ? req_sam :
    (wr_hc && !req_sam) ? 1'b0 : own_sam_ff; // R6
  wire nxt_unlock =
    wr_hc ? (!unlock_ff && reg_wdata_in[rcf_pkg::HC_UNLOCK_BIT]) : unlock_ff; // R4

  // Read multiplexer
  wire [rcf_pkg::DATA_W-1:0] rd_cmd =
    {standby_ff, rf_off_ff, 1'b0, cmd_ff}; // R3
  wire [rcf_pkg::DATA_W-1:0] rd_hc =
    {unlock_ff, own_host_ff, own_sam_ff, 1'b0, link_ff, 2'b00};
  wire [rcf_pkg::DATA_W-1:0] rd_qc =
    {depth_sel_ff, near_full, near_empty, 1'b0, 1'b0, thr_msb_ff,
     count_ff[rcf_pkg::CNT_W-1:rcf_pkg::DATA_W]}; // R12 R14
  wire [rcf_pkg::DATA_W-1:0] rd_port_data =
    q_empty ? rcf_pkg::RST_BYTE : mem[rd_ptr_ff]; // R18
  wire [rcf_pkg::DATA_W-1:0] rd_mux =
    sel_cmd ? rd_cmd :
    sel_hc ? rd_hc :
    sel_qc ? rd_qc :
    sel_thr ? thr_lo_ff :
    sel_cnt ? count_ff[rcf_pkg::DATA_W-1:0] : // R17
    sel_port ? rd_port_data : rcf_pkg::RST_BYTE;
  wire rd_any = reg_rd_in && !reg_wr_in;

  // Queue storage write
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= reg_wdata_in;
    end
  end

  // Command register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      standby_ff <= 1'b0;
      rf_off_ff <= 1'b0;
      cmd_ff <= rcf_pkg::RST_CMD;
    end else if (wr_cmd) begin
      standby_ff <= reg_wdata_in[rcf_pkg::CMD_STANDBY_BIT]; // R1
      rf_off_ff <= reg_wdata_in[rcf_pkg::CMD_RF_OFF_BIT]; // R2
      cmd_ff <= reg_wdata_in[rcf_pkg::CMD_CODE_MSB:0]; // R3
    end
  end

  // Host-access control register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      unlock_ff <= 1'b0;
      own_host_ff <= 1'b0;
      own_sam_ff <= 1'b0;
      link_ff <= rcf_pkg::RST_LINK;
    end else begin
      unlock_ff <= nxt_unlock; // R4
      own_host_ff <= nxt_own_host;
      own_sam_ff <= nxt_own_sam;
      if (wr_hc) begin
        link_ff <= reg_wdata_in[rcf_pkg::HC_LINK_MSB:rcf_pkg::HC_LINK_LSB]; // R7
      end
    end
  end

  // Queue control and threshold registers
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      depth_sel_ff <= 1'b0;
      thr_msb_ff <= 1'b0;
      thr_lo_ff <= rcf_pkg::RST_BYTE;
    end else begin
      if (wr_qc) begin
        depth_sel_ff <= reg_wdata_in[rcf_pkg::QC_DEPTH_BIT]; // R8
        thr_msb_ff <= reg_wdata_in[rcf_pkg::QC_THR_MSB_BIT]; // R13
      end
      if (wr_thr) begin
        thr_lo_ff <= reg_wdata_in; // R15
      end
    end
  end

  // Queue pointers and fill count
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= rcf_pkg::RST_COUNT; // R17
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count; // R16
    end
  end

  // Read answer and registered flags
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_ff <= rcf_pkg::RST_BYTE;
      rvalid_ff <= 1'b0;
      near_full_ff <= 1'b0;
      near_empty_ff <= 1'b1;
    end else begin
      rvalid_ff <= rd_any;
      if (rd_any) begin
        rdata_ff <= rd_mux;
      end
      near_full_ff <= near_full;
      near_empty_ff <= near_empty;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;
  assign standby_out = standby_ff;
  assign rf_frontend_powerdown_out = rf_off_ff;
  assign command_code_out = cmd_ff;
  assign bus_owner_host_out = own_host_ff;
  assign bus_owner_secure_module_out = own_sam_ff;
  assign secure_module_link_select_out = link_ff;
  assign near_full_flag_out = near_full_ff;
  assign near_empty_flag_out = near_empty_ff;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_standby_entry: assert property ( // R1
    wr_cmd && reg_wdata_in[rcf_pkg::CMD_STANDBY_BIT]
    |=> standby_out && (rd_cmd[rcf_pkg::CMD_STANDBY_BIT] == 1'b1))
    else $error("standby not entered");

  a_frontend_off: assert property ( // R2
    wr_cmd |=> rf_frontend_powerdown_out == $past(reg_wdata_in[rcf_pkg::CMD_RF_OFF_BIT]))
    else $error("frontend powerdown does not follow write");

  a_cmd_reserved: assert property ( // R3
    rd_any && sel_cmd
    |=> reg_rdata_out == {standby_out, rf_frontend_powerdown_out, 1'b0, command_code_out})
    else $error("reserved command bit not zero");

  a_unlock_clears: assert property ( // R4
    wr_hc && unlock_ff |=> !unlock_ff)
    else $error("unlock not cleared by write");

  a_host_locked: assert property ( // R5
    wr_hc && !unlock_ff && !own_host_ff |=> !bus_owner_host_out)
    else $error("host ownership set while locked");

  a_owner_exclusive: assert property ( // R6
    !(bus_owner_host_out && bus_owner_secure_module_out))
    else $error("both bus owners set");

  a_link_select: assert property ( // R7
    wr_hc |=> secure_module_link_select_out == $past(reg_wdata_in[3:2]))
    else $error("link select not stored");

  a_near_full: assert property ( // R10
    ##1 near_full_flag_out == ({1'b0, $past(count_ff)} + {2'b00, $past(threshold)} >=
      {1'b0, ($past(depth_sel_ff) ? rcf_pkg::DEPTH_SMALL : rcf_pkg::DEPTH_LARGE)}))
    else $error("near full flag wrong");

  a_near_empty: assert property ( // R11
    ##1 near_empty_flag_out == ($past(count_ff) <= {1'b0, $past(threshold)}))
    else $error("near empty flag wrong");

  a_queue_clear: assert property ( // R12
    q_clear |=> count_ff == rcf_pkg::RST_COUNT && wr_ptr_ff == rd_ptr_ff)
    else $error("clear did not empty queue");

  a_push_count: assert property ( // R16
    push && !q_clear |=> count_ff == $past(count_ff) + 10'h001)
    else $error("push did not increment count");

  a_pop_empty: assert property ( // R18
    rd_port && q_empty |=> count_ff == rcf_pkg::RST_COUNT && reg_rdata_out == 8'h00)
    else $error("empty read not zero");

  a_full_drop: assert property ( // R18
    wr_port && q_full && !q_clear |=> count_ff == $past(count_ff))
    else $error("full write changed count");

  a_both_owners: assert property ( // R19
    wr_hc && unlock_ff && both_req
    |=> bus_owner_host_out == $past(own_host_ff)
        && bus_owner_secure_module_out == $past(own_sam_ff))
    else $error("double ownership request changed owners");

  a_pop_count: assert property ( // R16
    pop |=> count_ff == $past(count_ff) - 10'h001)
    else $error("pop did not decrement count");

  a_fill_low: assert property ( // R17
    rd_any && sel_cnt |=> reg_rdata_out == $past(count_ff[rcf_pkg::DATA_W-1:0]))
    else $error("fill count read wrong");

  a_fill_msbs: assert property ( // R14
    rd_any && sel_qc
    |=> reg_rdata_out[1:0] == $past(count_ff[rcf_pkg::CNT_W-1:rcf_pkg::DATA_W]))
    else $error("fill count upper bits wrong");

  a_clear_reads_zero: assert property ( // R12
    rd_any && sel_qc |=> !reg_rdata_out[rcf_pkg::QC_CLEAR_BIT])
    else $error("clear bit did not read zero");

  a_thr_store: assert property ( // R15
    wr_thr |=> thr_lo_ff == $past(reg_wdata_in))
    else $error("threshold not stored");

  a_small_cap: assert property ( // R8
    wr_port && depth_sel_ff && count_ff >= rcf_pkg::DEPTH_SMALL
    |=> count_ff == $past(count_ff))
    else $error("small queue grew past its capacity");

  a_large_cap: assert property ( // R8
    wr_port && !depth_sel_ff && count_ff < rcf_pkg::DEPTH_LARGE
    |=> count_ff == $past(count_ff) + 10'h001)
    else $error("large queue refused a byte");

  a_thr_msb_ignored: assert property ( // R13
    depth_sel_ff |-> near_empty == (count_ff <= {2'b00, thr_lo_ff}))
    else $error("threshold msb used in small mode");

  a_thr_msb_used: assert property ( // R13
    !depth_sel_ff |-> near_empty == (count_ff <= {1'b0, thr_msb_ff, thr_lo_ff}))
    else $error("threshold msb ignored in large mode");

  a_cmd_code: assert property ( // R3
    wr_cmd |=> command_code_out == $past(reg_wdata_in[rcf_pkg::CMD_CODE_MSB:0]))
    else $error("command code not stored");

  a_sam_locked: assert property ( // R6
    wr_hc && !unlock_ff && !own_sam_ff |=> !bus_owner_secure_module_out)
    else $error("secure module ownership set while locked");

  a_unlock_set: assert property ( // R4
    wr_hc && !unlock_ff && reg_wdata_in[rcf_pkg::HC_UNLOCK_BIT] |=> unlock_ff)
    else $error("unlock not set by write");

  a_host_grant: assert property ( // R5
    wr_hc && unlock_ff && reg_wdata_in[rcf_pkg::HC_OWN_HOST_BIT]
      && !reg_wdata_in[rcf_pkg::HC_OWN_SAM_BIT] |=> bus_owner_host_out)
    else $error("unlocked host request not granted");

  a_empty_read_ptr: assert property ( // R18
    rd_port && q_empty |=> rd_ptr_ff == $past(rd_ptr_ff))
    else $error("empty read moved read pointer");

endmodule

// >>> test/rcf_host_model.sv
// Host-side register access model for the command and queue block
module rcf_host_model (
  input wire logic core_clk_in,
  output logic [rcf_pkg::ADDR_W-1:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [rcf_pkg::DATA_W-1:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_out = 7'h7F;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // One strobe per access, held across one rising edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge core_clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [6:0] a);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge core_clk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
  endtask
  // Depth changes only together with a queue clear
  task automatic set_depth(input logic dsel, input logic msb);
    wr(rcf_pkg::ADR_QUEUE_CTRL, {dsel, 3'b001, 1'b0, msb, 2'b00});
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the command, host-access and queue registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in;
  logic rstn_in;
  logic [6:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic standby_out, rf_frontend_powerdown_out, bus_owner_host_out;
  logic bus_owner_secure_module_out, near_full_flag_out, near_empty_flag_out;
  logic [4:0] command_code_out;
  logic [1:0] link;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  logic [7:0] data_q[$];
  int fails = 0;
  int checks_done = 0;
  rcf_host_model HOST (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata));
  rcf_top #(.PTR_W(9)) DUT (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .standby_out(standby_out),
    .rf_frontend_powerdown_out(rf_frontend_powerdown_out),
    .command_code_out(command_code_out), .bus_owner_host_out(bus_owner_host_out),
    .bus_owner_secure_module_out(bus_owner_secure_module_out),
    .secure_module_link_select_out(link), .near_full_flag_out(near_full_flag_out),
    .near_empty_flag_out(near_empty_flag_out));
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    HOST.rd(a);
  endtask
  task automatic push_n(input int n);
    for (int i = 0; i < n; i++) begin
      v = 8'($urandom);
      data_q.push_back(v);
      HOST.wr(rcf_pkg::ADR_QUEUE_PORT, v);
    end
  endtask
  task automatic pop_n(input int n);
    for (int i = 0; i < n; i++) rd_exp(rcf_pkg::ADR_QUEUE_PORT, data_q.pop_front());
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Read results are compared in arrival order
  always @(negedge core_clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) chk(reg_rdata_out, 8'hXX, "unrequested read");
      else chk(reg_rdata_out, exp_q.pop_front(), "read data");
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    rstn_in = 1'b0;
    void'($urandom(32'h4c4b));
    repeat (16) @(negedge core_clk_in);
    rstn_in = 1'b1;
    chk({6'h00, near_full_flag_out, near_empty_flag_out}, 8'h01, "reset flags");
    rd_exp(rcf_pkg::ADR_COMMAND, 8'h00);
    rd_exp(rcf_pkg::ADR_HOST_CTRL, 8'h00);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'h20);
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'h00);
    rd_exp(7'h55, 8'h00);
    $display("test reset done");
    repeat (6) begin
      v = 8'($urandom);
      HOST.wr(rcf_pkg::ADR_COMMAND, v);
      chk({standby_out, rf_frontend_powerdown_out, 1'b0, command_code_out}, v & 8'hDF, "cmd");
      rd_exp(rcf_pkg::ADR_COMMAND, v & 8'hDF);
    end
    $display("test command done");
    HOST.wr(rcf_pkg::ADR_HOST_CTRL, 8'h60);
    chk({6'h00, bus_owner_host_out, bus_owner_secure_module_out}, 8'h00, "locked");
    HOST.wr(rcf_pkg::ADR_HOST_CTRL, 8'h80);
    HOST.wr(rcf_pkg::ADR_HOST_CTRL, 8'h60);
    chk({6'h00, bus_owner_host_out, bus_owner_secure_module_out}, 8'h00, "both");
    rd_exp(rcf_pkg::ADR_HOST_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, i[0], ~i[0], 1'b0, i[1:0], 2'b00};
      HOST.wr(rcf_pkg::ADR_HOST_CTRL, 8'h80);
      HOST.wr(rcf_pkg::ADR_HOST_CTRL, v);
      chk({4'h0, bus_owner_host_out, bus_owner_secure_module_out, link},
        {4'h0, i[0], ~i[0], i[1:0]}, "owner link");
      rd_exp(rcf_pkg::ADR_HOST_CTRL, v);
    end
    HOST.wr(rcf_pkg::ADR_HOST_CTRL, 8'h20);
    chk({6'h00, bus_owner_host_out, bus_owner_secure_module_out}, 8'h00, "relock");
    $display("test host access done");
    HOST.set_depth(1'b1, 1'b1);
    HOST.wr(rcf_pkg::ADR_THRESHOLD, 8'h05);
    rd_exp(rcf_pkg::ADR_THRESHOLD, 8'h05);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'hA4);
    push_n(255);
    HOST.wr(rcf_pkg::ADR_QUEUE_PORT, 8'h5A);
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'hFF);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'hC4);
    chk({6'h00, near_full_flag_out, near_empty_flag_out}, 8'h02, "full pins");
    pop_n(3);
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'hFC);
    HOST.set_depth(1'b1, 1'b1);
    data_q.delete();
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'h00);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'hA4);
    rd_exp(rcf_pkg::ADR_QUEUE_PORT, 8'h00);
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'h00);
    $display("test small queue done");
    HOST.set_depth(1'b0, 1'b1);
    push_n(300);
    rd_exp(rcf_pkg::ADR_FILL_COUNT, 8'h2C);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'h45);
    chk({6'h00, near_full_flag_out, near_empty_flag_out}, 8'h02, "large pins");
    pop_n(300);
    rd_exp(rcf_pkg::ADR_QUEUE_CTRL, 8'h24);
    $display("test large queue done");
    repeat (4) @(negedge core_clk_in);
    chk(8'(exp_q.size()), 8'h00, "pending reads");
    finish_test();
  end
endmodule
